// ---- logic/ppm_top.sv ----
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module ppm_top #(
   parameter int IRQ_PULSE = ppm_pkg::IRQ_PULSE_CYC,
   parameter int EPP_TIMEOUT = ppm_pkg::EPP_TIMEOUT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ppm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic printer_select_out,
   output logic printer_select_oe,
   output logic printer_initialise_out,
   output logic printer_initialise_oe,
   output logic auto_line_feed_out,
   output logic auto_line_feed_oe,
   output logic data_strobe_out,
   output logic data_strobe_oe,
   input wire logic printer_busy_in,
   input wire logic printer_acknowledge_in,
   input wire logic paper_out_in,
   input wire logic printer_online_in,
   input wire logic printer_fault_in,
   input wire logic [7:0] port_data_in,
   output logic [7:0] port_data_out,
   output logic port_data_oe,
   input wire logic power_valid_in,
   output logic irq_out,
   output logic irq_oe
);
   import ppm_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [IN_W-1:0] st_raw;
   logic [IN_W-1:0] st_s;
   logic [IN_W-1:0] st_g;
   logic [7:0] pd_s;
   logic pwr_ok;

   assign st_raw = {printer_busy_in, printer_acknowledge_in, paper_out_in,
                    printer_online_in, printer_fault_in};

   ppm_sync #(.W(IN_W)) u_sync_st (
      .pclk(pclk),
      .presetn(presetn),
      .d(st_raw),
      .q(st_s)
   );

   ppm_sync #(.W(8)) u_sync_pd (
      .pclk(pclk),
      .presetn(presetn),
      .d(port_data_in),
      .q(pd_s)
   );

   ppm_sync #(.W(1)) u_sync_pwr (
      .pclk(pclk),
      .presetn(presetn),
      .d(power_valid_in),
      .q(pwr_ok)
   );

   // disconnected inputs read as low
   assign st_g = pwr_ok ? st_s : '0;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic cfg_en;
   ppm_mode_t cfg_mode;
   logic [10:0] cfg_base;
   logic [7:0] ctl_reg;
   logic [7:0] data_reg;
   logic [7:0] ecp_reg [4];
   ppm_state_t state;
   logic epp_wr;
   logic [10:0] epp_cnt;
   logic [7:0] irq_cnt;
   logic ack_prev;
   logic enhanced;

   assign enhanced = (cfg_mode == PPM_MODE_EPP) || (cfg_mode == PPM_MODE_ECP);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic cfg_space;
   logic [10:0] io_addr;
   logic [10:0] rel;
   logic hit_std;
   logic hit_epp;
   logic hit_ecp;
   logic hit_ctrl;
   logic hit_base;
   logic addr_ok;
   logic acc_ok;
   logic setup;
   logic wr_fire;
   logic [7:0] status_byte;
   logic [7:0] rd_byte;

   assign cfg_space = paddr[CFG_SPACE_BIT];
   assign io_addr = paddr[IO_ADDR_MSB:IO_ADDR_LSB];
   assign rel = io_addr - cfg_base;
   // decode depends on cfg_en, cfg_mode and the offset from cfg_base
   assign hit_std = cfg_en && (rel <= OFS_STD_HI);
   assign hit_epp = cfg_en && (cfg_mode == PPM_MODE_EPP) && (rel >= OFS_EPP_LO)
                    && (rel <= OFS_EPP_HI);
   assign hit_ecp = cfg_en && (cfg_mode == PPM_MODE_ECP) && (rel >= OFS_ECP_LO)
                    && (rel <= OFS_ECP_HI);
   assign hit_ctrl = (paddr == CFG_CTRL_ADDR);
   assign hit_base = (paddr == CFG_BASE_ADDR);
   assign addr_ok = cfg_space ? (hit_ctrl || hit_base)
                    : ((paddr[14:13] == 2'h0) && (hit_std || hit_epp || hit_ecp));
   assign acc_ok = addr_ok && pwr_ok && (paddr[1:0] == 2'h0);

   assign setup = psel && !penable;
   assign pready = (state == S_RESP);
   assign wr_fire = psel && penable && pready && pwrite && !pslverr;

   assign status_byte = {~st_g[IN_BUSY], st_g[IN_ACK], st_g[IN_PAPER],
                         st_g[IN_ONLINE], st_g[IN_FAULT], 3'h0};

   always_comb begin
      rd_byte = 8'h00;
      if (cfg_space) begin
         if (hit_ctrl) begin
            rd_byte = {5'h00, cfg_mode, cfg_en};
         end else if (hit_base) begin
            rd_byte = cfg_base[7:0];
         end
      end else if (hit_ecp) begin
         rd_byte = ecp_reg[rel[1:0]];
      end else if (hit_std) begin
         unique case (rel)
            OFS_DATA: rd_byte = data_reg;
            OFS_STATUS: rd_byte = status_byte;
            OFS_CONTROL: rd_byte = ctl_reg;
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // bus sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         epp_wr <= 1'b0;
         epp_cnt <= 11'h000;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (setup) begin
                  if (acc_ok && !cfg_space && hit_epp) begin
                     state <= S_EPP_WAIT;
                     epp_wr <= pwrite;
                     epp_cnt <= 11'(EPP_TIMEOUT);
                  end else begin
                     state <= S_RESP;
                     prdata <= acc_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
                     pslverr <= !acc_ok;
                  end
               end
            end
            S_EPP_WAIT: begin
               // peripheral raises busy when the cycle may end
               if (st_g[IN_BUSY] || !pwr_ok || epp_cnt == 11'h000) begin
                  state <= S_RESP;
                  // refused or write cycles return zero data
                  prdata <= {24'h000000, (epp_wr || !st_g[IN_BUSY]) ? 8'h00 : pd_s};
                  pslverr <= !st_g[IN_BUSY];
               end else begin
                  epp_cnt <= epp_cnt - 11'h001;
               end
            end
            S_RESP: begin
               state <= S_IDLE;
               pslverr <= 1'b0;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_en <= 1'b0;
         cfg_mode <= PPM_MODE_SPP;
         cfg_base <= CFG_BASE_RESET;
      end else if (wr_fire && cfg_space) begin
         if (hit_ctrl) begin
            cfg_en <= pwdata[CFG_EN_BIT];
            cfg_mode <= ppm_mode_t'(pwdata[CFG_MODE_MSB:CFG_MODE_LSB]);
         end else if (hit_base) begin
            cfg_base <= pwdata[10:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // port registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= CTL_RESET;
      end else if (wr_fire && !cfg_space && hit_std && rel == OFS_CONTROL) begin
         ctl_reg <= pwdata[7:0] & CTL_WR_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_reg <= DATA_RESET;
      end else if (wr_fire && !cfg_space && hit_std && rel == OFS_DATA) begin
         data_reg <= pwdata[7:0];
      end else if (state == S_IDLE && setup && acc_ok && !cfg_space && hit_epp
                   && pwrite) begin
         data_reg <= pwdata[7:0];
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_ecp
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ecp_reg[i] <= 8'h00;
         end else if (wr_fire && !cfg_space && hit_ecp && rel[1:0] == 2'(i)) begin
            ecp_reg[i] <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // port data lines
   // ----------------------------------------------------------------
   logic epp_active;

   assign epp_active = (state == S_EPP_WAIT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_data_out <= 8'h00;
         port_data_oe <= 1'b0;
      end else begin
         port_data_out <= data_reg;
         port_data_oe <= pwr_ok && !ctl_reg[CTL_DIR] && !(epp_active && !epp_wr);
      end
   end

   // ----------------------------------------------------------------
   // control pins
   // ----------------------------------------------------------------
   ppm_pin_if pins ();

   // an EPP cycle raises the auto line feed request, and the strobe request on writes
   assign pins.ctl_req = ctl_reg[3:0] | (epp_active ? {2'h0, 1'h1, epp_wr} : 4'h0);
   assign pins.enhanced = enhanced;
   assign pins.pwr_ok = pwr_ok;

   ppm_pin_drive u_drive (
      .pclk(pclk),
      .presetn(presetn),
      .p(pins.drv)
   );

   assign data_strobe_out = pins.pin_out[CTL_STROBE];
   assign data_strobe_oe = pins.pin_oe[CTL_STROBE];
   assign auto_line_feed_out = pins.pin_out[CTL_AUTOFD];
   assign auto_line_feed_oe = pins.pin_oe[CTL_AUTOFD];
   assign printer_initialise_out = pins.pin_out[CTL_INIT];
   assign printer_initialise_oe = pins.pin_oe[CTL_INIT];
   assign printer_select_out = pins.pin_out[CTL_SELECT];
   assign printer_select_oe = pins.pin_oe[CTL_SELECT];

   // ----------------------------------------------------------------
   // interrupt line
   // ----------------------------------------------------------------
   logic ack_fall;

   assign ack_fall = ack_prev && !st_g[IN_ACK];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_prev <= 1'b0;
         irq_cnt <= 8'h00;
      end else begin
         ack_prev <= st_g[IN_ACK];
         if (enhanced && cfg_en && ctl_reg[CTL_IRQ_EN] && ack_fall) begin
            irq_cnt <= 8'(IRQ_PULSE);
         end else if (irq_cnt != 8'h00) begin
            irq_cnt <= irq_cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_out <= 1'b0;
         irq_oe <= 1'b0;
      end else if (!pwr_ok) begin
         irq_out <= 1'b0;
         irq_oe <= 1'b0;
      end else if (enhanced) begin
         // shared line: drive low for the pulse, else release
         irq_out <= 1'b0;
         irq_oe <= (irq_cnt != 8'h00);
      end else begin
         irq_out <= ctl_reg[CTL_IRQ_EN] && !st_g[IN_ACK];
         irq_oe <= cfg_en;
      end
   end

endmodule

// ---- logic/ppm_pkg.sv ----
package ppm_pkg;

   // ----------------------------------------------------------------
   // bus and address map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int IO_ADDR_W = 11;
   localparam int CFG_SPACE_BIT = 15;
   localparam int IO_ADDR_LSB = 2;
   localparam int IO_ADDR_MSB = 12;
   localparam logic [15:0] CFG_CTRL_ADDR = 16'h8000;
   localparam logic [15:0] CFG_BASE_ADDR = 16'h8004;

   // port window offsets, each a register index (byte address = 4 x index)
   localparam logic [10:0] OFS_DATA = 11'h000;
   localparam logic [10:0] OFS_STATUS = 11'h001;
   localparam logic [10:0] OFS_CONTROL = 11'h002;
   localparam logic [10:0] OFS_STD_HI = 11'h003;
   localparam logic [10:0] OFS_EPP_LO = 11'h004;
   localparam logic [10:0] OFS_EPP_HI = 11'h007;
   localparam logic [10:0] OFS_ECP_LO = 11'h400;
   localparam logic [10:0] OFS_ECP_HI = 11'h403;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTL_STROBE = 0;
   localparam int CTL_AUTOFD = 1;
   localparam int CTL_INIT = 2;
   localparam int CTL_SELECT = 3;
   localparam int CTL_IRQ_EN = 4;
   localparam int CTL_DIR = 5;
   localparam logic [7:0] CTL_WR_MASK = 8'h3F;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [3:0] CTL_INVERT_MASK = 4'hB;

   localparam int ST_FAULT = 3;
   localparam int ST_ONLINE = 4;
   localparam int ST_PAPER = 5;
   localparam int ST_ACK = 6;
   localparam int ST_BUSY = 7;

   // order of the synchronised status input vector
   localparam int IN_FAULT = 0;
   localparam int IN_ONLINE = 1;
   localparam int IN_PAPER = 2;
   localparam int IN_ACK = 3;
   localparam int IN_BUSY = 4;
   localparam int IN_W = 5;

   localparam int CFG_EN_BIT = 0;
   localparam int CFG_MODE_LSB = 1;
   localparam int CFG_MODE_MSB = 2;
   localparam logic [10:0] CFG_BASE_RESET = 11'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int IRQ_PULSE_NS = 100;
   localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EPP_TIMEOUT_NS = 10000;
   localparam int EPP_TIMEOUT_CYC = EPP_TIMEOUT_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PPM_MODE_SPP = 2'h0,
      PPM_MODE_EPP = 2'h1,
      PPM_MODE_ECP = 2'h2
   } ppm_mode_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_EPP_WAIT = 3'h2,
      S_RESP = 3'h4
   } ppm_state_t;

endpackage

// ---- logic/ppm_pin_if.sv ----
`timescale 1ns/1ps
interface ppm_pin_if;
   logic [3:0] ctl_req;
   logic enhanced;
   logic pwr_ok;
   logic [3:0] pin_out;
   logic [3:0] pin_oe;

   modport core (output ctl_req, output enhanced, output pwr_ok, input pin_out, input pin_oe);
   modport drv (input ctl_req, input enhanced, input pwr_ok, output pin_out, output pin_oe);
endinterface

// ---- logic/ppm_sync.sv ----
`timescale 1ns/1ps
module ppm_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ---- logic/ppm_pin_drive.sv ----
`timescale 1ns/1ps
module ppm_pin_drive (
   input wire logic pclk,
   input wire logic presetn,
   ppm_pin_if.drv p
);
   import ppm_pkg::*;

   logic [3:0] out_q;
   logic [3:0] oe_q;

   // ----------------------------------------------------------------
   // one driver per control line
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_line
      logic lvl;
      assign lvl = p.ctl_req[i] ^ CTL_INVERT_MASK[i];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            out_q[i] <= 1'b0;
            oe_q[i] <= 1'b0;
         end else if (!p.pwr_ok) begin
            out_q[i] <= 1'b0;
            oe_q[i] <= 1'b0;
         end else if (p.enhanced) begin
            out_q[i] <= lvl;
            oe_q[i] <= 1'b1;
         end else begin
            // open drain: pull low only
            out_q[i] <= 1'b0;
            oe_q[i] <= ~lvl;
         end
      end
   end

   assign p.pin_out = out_q;
   assign p.pin_oe = oe_q;
endmodule

// ---- tb/ppm_top_props.sv ----
`timescale 1ns/1ps
module ppm_top_props #(
   parameter int IRQ_PULSE = 10,
   parameter int EPP_TIMEOUT = 1000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ppm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic printer_select_out,
   input wire logic printer_select_oe,
   input wire logic printer_initialise_out,
   input wire logic printer_initialise_oe,
   input wire logic auto_line_feed_out,
   input wire logic auto_line_feed_oe,
   input wire logic data_strobe_out,
   input wire logic data_strobe_oe,
   input wire logic port_data_oe,
   input wire logic power_valid_in,
   input wire logic irq_out,
   input wire logic irq_oe
);
   import ppm_pkg::*;
   logic en, enh, cfg_wr;
   logic [1:0] mode;
   logic [7:0] pulse_cnt;
   logic [3:0] po, pe;
   assign cfg_wr = psel && penable && pready && pwrite && !pslverr && paddr == CFG_CTRL_ADDR;
   assign enh = en && (mode == 2'h1 || mode == 2'h2);
   assign po = {printer_select_out, printer_initialise_out, auto_line_feed_out, data_strobe_out};
   assign pe = {printer_select_oe, printer_initialise_oe, auto_line_feed_oe, data_strobe_oe};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------
   // mode tracking and pulse length
   // ------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en <= 1'h0;
         mode <= 2'h0;
      end else if (cfg_wr) begin
         en <= pwdata[CFG_EN_BIT];
         mode <= pwdata[CFG_MODE_MSB:CFG_MODE_LSB];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt <= 8'h00;
      end else if (!enh || !irq_oe) begin
         pulse_cnt <= 8'h00;
      end else if (!irq_out) begin
         pulse_cnt <= pulse_cnt + 8'h01;
      end
   end
   property p_rdata_width;
      pready |-> prdata[31:8] == 24'h0;
   endproperty
   a_rdata_width: assert property (p_rdata_width) else $error("read data above bit 7");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready held");
   property p_bad_addr;
      pready && (paddr[1:0] != 2'h0 || (!paddr[CFG_SPACE_BIT] && paddr[14:13] != 2'h0))
         |-> pslverr && prdata == 32'h0;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("bad address answered");
   property p_disabled;
      pready && !paddr[CFG_SPACE_BIT] && !en |-> pslverr;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled port answered");
   property p_pwr_release;
      (!power_valid_in) [*5] |-> pe == 4'h0 && !port_data_oe && !irq_oe;
   endproperty
   a_pwr_release: assert property (p_pwr_release) else $error("output driven");
   property p_pwr_refuse;
      (!power_valid_in) [*5] ##0 pready |-> pslverr;
   endproperty
   a_pwr_refuse: assert property (p_pwr_refuse) else $error("access taken");
   property p_open_drain;
      power_valid_in [*5] |-> (po & ~pe) == 4'h0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("high while released");
   property p_push_pull;
      (power_valid_in && enh) [*5] |-> pe == 4'hF;
   endproperty
   a_push_pull: assert property (p_push_pull) else $error("pin not push-pull");
   property p_irq_pulse;
      enh && power_valid_in && $fell(irq_oe) |-> pulse_cnt == IRQ_PULSE;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse length");
   property p_irq_bound;
      enh |-> pulse_cnt <= IRQ_PULSE;
   endproperty
   a_irq_bound: assert property (p_irq_bound) else $error("irq pulse too long");
   c_irq: cover property (enh && $fell(irq_oe));
   c_refused: cover property (pready && pslverr);
   c_stretch: cover property (psel && penable && !pready ##1 pready);
endmodule
bind ppm_top ppm_top_props #(.IRQ_PULSE(IRQ_PULSE), .EPP_TIMEOUT(EPP_TIMEOUT)) u_props (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .printer_select_out, .printer_select_oe, .printer_initialise_out, .printer_initialise_oe,
   .auto_line_feed_out, .auto_line_feed_oe, .data_strobe_out, .data_strobe_oe,
   .port_data_oe, .power_valid_in, .irq_out, .irq_oe
);

// ---- tb/ppm_printer_model.sv ----
`timescale 1ns/1ps
module ppm_printer_model (
   input wire logic pclk,
   input wire logic epp_en,
   input wire logic [2:0] dly,
   input wire logic [4:0] st,
   input wire logic [7:0] rd_byte,
   input wire logic lf_lvl,
   input wire logic [7:0] pd_out,
   input wire logic pd_oe,
   output logic [4:0] pins,
   output logic [7:0] pd_in
);
   logic [2:0] cnt = 3'h0;
   logic hs_busy = 1'h0;
   // busy rises dly + 1 cycles after the host strobe falls
   always @(posedge pclk) begin
      if (epp_en && !lf_lvl) begin
         if (cnt == dly) begin
            hs_busy <= 1'h1;
         end else begin
            cnt <= cnt + 3'h1;
         end
      end else begin
         cnt <= 3'h0;
         hs_busy <= 1'h0;
      end
   end
   // busy drops as soon as the host strobe is raised again
   assign pins = {epp_en ? (hs_busy && lf_lvl == 1'h0) : st[4], st[3:0]};
   // host owns the shared lines while it drives them
   assign pd_in = pd_oe ? pd_out : rd_byte;
endmodule

// ---- tb/test_printer_port_pin_mapping.sv ----
`timescale 1ns/1ps
module test_printer_port_pin_mapping;
   import ppm_pkg::*;
   localparam int PULSE = 4;
   logic pclk, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic power_valid_in = 1'h1, epp_en = 1'h0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, port_data_oe, irq_out, irq_oe;
   logic printer_select_out, printer_select_oe, printer_initialise_out, printer_initialise_oe;
   logic auto_line_feed_out, auto_line_feed_oe, data_strobe_out, data_strobe_oe;
   logic [2:0] dly = 3'h2;
   logic [4:0] st = 5'h08;
   logic [7:0] rd_byte = 8'h00, port_data_out, v;
   wire printer_busy_in, printer_acknowledge_in, paper_out_in, printer_online_in;
   wire printer_fault_in;
   wire [7:0] port_data_in;
   logic [3:0] lv, po, pe;
   logic [10:0] base = 11'h000;
   logic [33:0] ex, exp_q[$];
   int error_cnt = 0, tests_run = 0, seed = 4283, n;
   ppm_top #(.IRQ_PULSE(PULSE), .EPP_TIMEOUT(20)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .printer_select_out, .printer_select_oe, .printer_initialise_out, .printer_initialise_oe,
      .auto_line_feed_out, .auto_line_feed_oe, .data_strobe_out, .data_strobe_oe,
      .printer_busy_in, .printer_acknowledge_in, .paper_out_in, .printer_online_in,
      .printer_fault_in, .port_data_in, .port_data_out, .port_data_oe, .power_valid_in,
      .irq_out, .irq_oe
   );
   ppm_printer_model model (
      .pclk, .epp_en, .dly, .st, .rd_byte, .lf_lvl(lv[1]), .pd_out(port_data_out),
      .pd_oe(port_data_oe), .pd_in(port_data_in),
      .pins({printer_busy_in, printer_acknowledge_in, paper_out_in, printer_online_in,
         printer_fault_in})
   );
   assign po = {printer_select_out, printer_initialise_out, auto_line_feed_out, data_strobe_out};
   assign pe = {printer_select_oe, printer_initialise_oe, auto_line_feed_oe, data_strobe_oe};
   // released pins are pulled up
   assign lv = (po & pe) | ~pe;
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   // ------
   // bus tasks and checking
   // ------
   task check(input string what, input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd, input logic [33:0] e);
      int k;
      exp_q.push_back(e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      @(negedge pclk);
      while (pready !== 1'h1 && k < 2000) begin
         k++;
         @(negedge pclk);
      end
      if (k >= 2000) begin
         error_cnt++;
         summarize();
      end
      @(posedge pclk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d, input logic err);
      apb(1'h1, a, d, {err, err, 32'h0});
   endtask
   task rd(input logic [15:0] a, input logic [31:0] d, input logic err);
      apb(1'h0, a, 32'h0, {1'h1, err, d});
   endtask
   function automatic logic [15:0] io(input logic [10:0] r);
      return {3'h0, base + r, 2'h0};
   endfunction
   always @(negedge pclk) begin
      if (pready === 1'h1) begin
         ex = exp_q.pop_front();
         check("pslverr", pslverr, ex[32]);
         if (ex[33]) check("prdata", prdata, ex[31:0]);
      end
   end
   task summarize();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      rd(io(OFS_DATA), 32'h0, 1'h1);
      rd(16'h8001, 32'h0, 1'h1);
      rd(16'h2000, 32'h0, 1'h1);
      base = 11'h010 + 11'($random(seed) & 32'hFF);
      wr(CFG_BASE_ADDR, {21'h0, base}, 1'h0);
      wr(CFG_CTRL_ADDR, 32'h1, 1'h0);
      rd(io(OFS_STD_HI), 32'h0, 1'h0);
      rd(io(OFS_EPP_LO), 32'h0, 1'h1);
      rd(io(OFS_ECP_LO), 32'h0, 1'h1);
      v = 8'($random(seed));
      wr(io(OFS_DATA), {24'h0, v}, 1'h0);
      rd(io(OFS_DATA), {24'h0, v}, 1'h0);
      check("port_data_out", {port_data_oe, port_data_out}, {1'h1, v});
      for (int i = 0; i < 16; i++) begin
         wr(io(OFS_CONTROL), 32'(i), 1'h0);
         repeat (3) @(negedge pclk);
         check("pin level", lv, 4'(i) ^ CTL_INVERT_MASK);
         check("open drain", po, 4'h0);
      end
      wr(io(OFS_CONTROL), 32'hFFFF_FFE0, 1'h0);
      rd(io(OFS_CONTROL), 32'h20, 1'h0);
      check("data released", port_data_oe, 1'h0);
      for (int i = 0; i < 8; i++) begin
         st <= 5'($random(seed));
         repeat (4) @(negedge pclk);
         rd(io(OFS_STATUS), {24'h0, ~st[4], st[3:0], 3'h0}, 1'h0);
      end
      $display("standard mode tests done");
      st <= 5'h08;
      wr(CFG_CTRL_ADDR, 32'h0, 1'h0);
      wr(CFG_CTRL_ADDR, 32'h3, 1'h0);
      wr(io(OFS_CONTROL), 32'h10, 1'h0);
      epp_en <= 1'h1;
      repeat (4) @(negedge pclk);
      check("push-pull", pe, 4'hF);
      @(posedge pclk);
      for (int d = 0; d < 4; d++) begin
         v = 8'($random(seed));
         dly <= 3'(2 + d);
         rd_byte <= v;
         rd(io(11'(OFS_EPP_LO + d)), {24'h0, v}, 1'h0);
      end
      v = 8'($random(seed));
      wr(io(OFS_EPP_HI), {24'h0, v}, 1'h0);
      check("epp write", port_data_out, v);
      epp_en <= 1'h0;
      rd(io(OFS_EPP_LO), 32'h0, 1'h1);
      rd(io(OFS_ECP_LO), 32'h0, 1'h1);
      st <= 5'h00;
      n = 0;
      while (irq_oe !== 1'h1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      check("irq pulse", {irq_oe, irq_out}, 2'h2);
      repeat (PULSE + 1) @(negedge pclk);
      check("irq release", irq_oe, 1'h0);
      $display("enhanced mode tests done");
      @(posedge pclk);
      wr(CFG_CTRL_ADDR, 32'h0, 1'h0);
      wr(CFG_CTRL_ADDR, 32'h5, 1'h0);
      for (int i = 0; i < 4; i++) wr(io(11'(OFS_ECP_LO + i)), 32'h5A ^ i, 1'h0);
      for (int i = 0; i < 4; i++) rd(io(11'(OFS_ECP_LO + i)), 32'h5A ^ i, 1'h0);
      rd(io(OFS_EPP_LO), 32'h0, 1'h1);
      power_valid_in <= 1'h0;
      repeat (5) @(negedge pclk);
      check("released", {pe, port_data_oe, irq_oe}, 6'h00);
      wr(io(OFS_CONTROL), 32'h0F, 1'h1);
      wr(CFG_CTRL_ADDR, 32'h0, 1'h1);
      power_valid_in <= 1'h1;
      repeat (4) @(negedge pclk);
      rd(io(OFS_CONTROL), 32'h10, 1'h0);
      rd(io(OFS_ECP_LO), 32'h5A, 1'h0);
      $display("capability and power tests done");
      summarize();
   end
endmodule
